// File: design/motion_sample_rate_config.sv
/*
 * sample-rate generator, frame-sync capture, low-pass setting and
 * self-test / range control of a motion sensor readout, with an
 * 8-bit classic wishbone register slave.
 * assumes the front end delivers sensor words on i_clk_sys, and that
 * the frame-sync pin is asynchronous to it.
 */
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
`include "msrc_params.svh"
module motion_sample_rate_config #(
	parameter int unsigned GYRO_FAST_CYCLES =
		`MSRC_CLK_HZ / `MSRC_GYRO_FAST_HZ,
	parameter int unsigned GYRO_SLOW_CYCLES =
		`MSRC_CLK_HZ / `MSRC_GYRO_SLOW_HZ,
	parameter int unsigned ACCEL_CYCLES     =
		`MSRC_CLK_HZ / `MSRC_ACCEL_HZ
) (
	// clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_sys_rst,
	// register bus
	input  wire msrc_pkg::wb_req_s i_wb,
	output logic                  o_wb_ack,
	output logic [7:0]            o_wb_dat,
	// sensing front end
	input  wire logic             i_frame_sync,
	input  wire msrc_pkg::sample_s i_front,
	output logic [2:0]            o_gyro_selftest,
	output logic [2:0]            o_accel_selftest,
	output logic [1:0]            o_gyro_range,
	output logic [1:0]            o_accel_range,
	output logic [2:0]            o_lowpass_setting,
	// paced data to registers, fifo and motion processor
	output logic                  o_sample_tick,
	output msrc_pkg::sample_s     o_sample
);
	import msrc_pkg::*;

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic gyro_fast(input logic [2:0] lpf);
		gyro_fast = (lpf == `MSRC_LPF_OFF_A) || (lpf == `MSRC_LPF_OFF_B);
	endfunction : gyro_fast

	function automatic logic [`MSRC_CNT_W-1:0] gyro_last(
		input logic [2:0] lpf);
		if (gyro_fast(lpf)) begin
			gyro_last = `MSRC_CNT_W'(GYRO_FAST_CYCLES - 1);
		end else begin
			gyro_last = `MSRC_CNT_W'(GYRO_SLOW_CYCLES - 1);
		end
	endfunction : gyro_last

	// put the sync bit into bit 0 of the low byte named by the slot
	function automatic sample_s insert_sync(input sample_s s,
		input logic [2:0] slot, input logic b);
		sample_s r;
		r = s;
		if (slot == `MSRC_SLOT_TEMP) begin
			r.temp[0] = b;
		end else if (slot >= `MSRC_SLOT_GYRO && slot < `MSRC_SLOT_ACCEL) begin
			r.gyro[2'(slot - `MSRC_SLOT_GYRO)][0] = b;
		end else if (slot >= `MSRC_SLOT_ACCEL) begin
			r.accel[2'(slot - `MSRC_SLOT_ACCEL)][0] = b;
		end
		insert_sync = r;
	endfunction : insert_sync

	// the bit that the slot names, for checking
	function automatic logic slot_bit(input sample_s s,
		input logic [2:0] slot);
		if (slot == `MSRC_SLOT_TEMP) begin
			slot_bit = s.temp[0];
		end else if (slot >= `MSRC_SLOT_GYRO && slot < `MSRC_SLOT_ACCEL) begin
			slot_bit = s.gyro[2'(slot - `MSRC_SLOT_GYRO)][0];
		end else begin
			slot_bit = s.accel[2'(slot - `MSRC_SLOT_ACCEL)][0];
		end
	endfunction : slot_bit

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	state_s st;
	state_s next_st;
	logic [2:0] lpf;
	logic [2:0] slot;
	logic       wr_now;

	assign lpf    = st.filter_cfg[`MSRC_LPF_HI:`MSRC_LPF_LO];
	assign slot   = st.filter_cfg[`MSRC_SLOT_HI:`MSRC_SLOT_LO];
	assign wr_now = i_wb.cyc && i_wb.stb && i_wb.we && i_wb.sel && st.ack;

	always_comb begin
		logic fs_seen;
		sample_s raw;
		next_st = st;
		fs_seen = 1'b0;
		raw     = st.sample;
		// frame-sync pin synchroniser
		next_st.fs_s1 = i_frame_sync;
		next_st.fs_s2 = st.fs_s1;

		// gyro output rate, set by the lowpass setting
		if (st.gyro_cnt >= gyro_last(lpf)) begin
			next_st.gyro_cnt  = '0;
			next_st.gyro_tick = 1'b1;
		end else begin
			next_st.gyro_cnt  = st.gyro_cnt + 1'b1;
			next_st.gyro_tick = 1'b0;
		end

		// accel words are taken at their own fixed rate
		if (st.accel_cnt >= `MSRC_CNT_W'(ACCEL_CYCLES - 1)) begin
			next_st.accel_cnt  = '0;
			next_st.accel_hold = i_front.accel;
		end else begin
			next_st.accel_cnt = st.accel_cnt + 1'b1;
		end

		// any high level since the last reload stays caught
		fs_seen          = st.fs_latch | st.fs_s2;
		next_st.fs_latch = fs_seen;

		// sample rate: one tick every divider+1 gyro ticks
		next_st.sample_tick = 1'b0;
		if (st.gyro_tick) begin
			if (st.div_cnt >= st.divider) begin
				next_st.div_cnt     = '0;
				next_st.sample_tick = 1'b1;
				next_st.fs_sampled  = fs_seen;
				next_st.fs_latch    = st.fs_s2;
				raw.temp  = i_front.temp;
				raw.gyro  = i_front.gyro;
				raw.accel = next_st.accel_hold;
				// slot 0 leaves every lsb as measured
				next_st.sample = insert_sync(raw, slot, fs_seen);
			end else begin
				next_st.div_cnt = st.div_cnt + 1'b1;
			end
		end

		// wishbone slave: ack one cycle after the request, then drop
		next_st.ack = i_wb.cyc && i_wb.stb && !st.ack;
		if (i_wb.cyc && i_wb.stb && !st.ack) begin
			unique case (i_wb.adr)
				`MSRC_ADR_DIVIDER: next_st.rdata = st.divider;
				`MSRC_ADR_FILTER:  next_st.rdata = st.filter_cfg;
				`MSRC_ADR_GYRO:    next_st.rdata = st.gyro_cfg;
				`MSRC_ADR_ACCEL:   next_st.rdata = st.accel_cfg;
				`MSRC_ADR_STATUS: begin
					next_st.rdata = `MSRC_RD_NONE;
					next_st.rdata[`MSRC_STAT_FAST] = gyro_fast(lpf);
					next_st.rdata[`MSRC_STAT_SYNC] = st.fs_sampled;
				end
				default:           next_st.rdata = `MSRC_RD_NONE;
			endcase
		end
		// writes land on the edge at which the master sees ack
		if (wr_now) begin
			unique case (i_wb.adr)
				`MSRC_ADR_DIVIDER: next_st.divider = i_wb.dat;
				`MSRC_ADR_FILTER:
					next_st.filter_cfg = i_wb.dat & `MSRC_FILTER_MASK;
				`MSRC_ADR_GYRO:
					next_st.gyro_cfg = i_wb.dat & `MSRC_RANGE_MASK;
				`MSRC_ADR_ACCEL:
					next_st.accel_cfg = i_wb.dat & `MSRC_RANGE_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign o_wb_ack          = st.ack;
	assign o_wb_dat          = st.rdata;
	assign o_gyro_selftest   = st.gyro_cfg[`MSRC_ST_HI:`MSRC_ST_LO];
	assign o_accel_selftest  = st.accel_cfg[`MSRC_ST_HI:`MSRC_ST_LO];
	assign o_gyro_range      = st.gyro_cfg[`MSRC_RNG_HI:`MSRC_RNG_LO];
	assign o_accel_range     = st.accel_cfg[`MSRC_RNG_HI:`MSRC_RNG_LO];
	assign o_lowpass_setting = lpf;
	assign o_sample_tick     = st.sample_tick;
	assign o_sample          = st.sample;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	logic [`MSRC_CNT_W-1:0] h_gap;
	logic                   h_garmed;
	logic                   h_lpfchg;
	logic [8:0]             h_gticks;
	logic                   h_sarmed;
	logic                   h_divchg;

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			h_gap    <= '0;
			h_garmed <= 1'b0;
			h_lpfchg <= 1'b0;
			h_gticks <= '0;
			h_sarmed <= 1'b0;
			h_divchg <= 1'b0;
		end else begin
			if (st.gyro_tick) begin
				h_gap    <= '0;
				h_garmed <= 1'b1;
				h_lpfchg <= 1'b0;
			end else begin
				h_gap    <= h_gap + 1'b1;
				h_lpfchg <= h_lpfchg || (next_st.filter_cfg != st.filter_cfg);
			end
			if (st.sample_tick) begin
				h_gticks <= '0;
				h_sarmed <= 1'b1;
				h_divchg <= 1'b0;
			end else begin
				h_gticks <= h_gticks + 9'(st.gyro_tick);
				h_divchg <= h_divchg || (next_st.divider != st.divider);
			end
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence s_bus_write(logic [7:0] a);
		wr_now && i_wb.adr == a;
	endsequence

	sequence s_bus_read(logic [7:0] a);
		i_wb.cyc && i_wb.stb && !i_wb.we && !o_wb_ack && i_wb.adr == a;
	endsequence

	property p_rate_divide;
		st.sample_tick && h_sarmed && !h_divchg
			|-> h_gticks == {1'b0, st.divider} + 9'h001;
	endproperty
	a_rate_divide: assert property (p_rate_divide)
		else $error("sample tick spacing differs from divider plus one");

	property p_gyro_rate;
		st.gyro_tick && h_garmed && !h_lpfchg
			|-> h_gap == gyro_last(lpf);
	endproperty
	a_gyro_rate: assert property (p_gyro_rate)
		else $error("gyro tick period does not match lowpass setting");

	property p_paced_update;
		!o_sample_tick |-> $stable(o_sample);
	endproperty
	a_paced_update: assert property (p_paced_update)
		else $error("sample words changed without a sample tick");

	property p_accel_repeat;
		o_sample_tick && $past(slot) < `MSRC_SLOT_ACCEL
			|-> o_sample.accel == st.accel_hold;
	endproperty
	a_accel_repeat: assert property (p_accel_repeat)
		else $error("accel words are not the held accel sample");

	property p_divider_write;
		s_bus_write(`MSRC_ADR_DIVIDER) |=> st.divider == $past(i_wb.dat);
	endproperty
	a_divider_write: assert property (p_divider_write)
		else $error("divider did not take the written byte");

	property p_sync_capture;
		st.fs_s2 |=> st.fs_latch;
	endproperty
	a_sync_capture: assert property (p_sync_capture)
		else $error("frame-sync high level was not latched");

	property p_sync_reload;
		st.sample_tick |-> st.fs_sampled == $past(st.fs_latch | st.fs_s2)
			&& st.fs_latch == $past(st.fs_s2);
	endproperty
	a_sync_reload: assert property (p_sync_reload)
		else $error("frame-sync sample or reload is wrong");

	property p_sync_slot;
		o_sample_tick && $past(slot) != `MSRC_SLOT_OFF
			|-> slot_bit(o_sample, $past(slot)) == st.fs_sampled;
	endproperty
	a_sync_slot: assert property (p_sync_slot)
		else $error("sync bit not in the selected low byte");

	property p_sync_off;
		o_sample_tick && $past(slot) == `MSRC_SLOT_OFF
			|-> o_sample.temp[0] == $past(i_front.temp[0])
			&& o_sample.gyro[0][0] == $past(i_front.gyro[0][0]);
	endproperty
	a_sync_off: assert property (p_sync_off)
		else $error("lsb altered while sync reporting is off");

	property p_filter_reserved;
		s_bus_write(`MSRC_ADR_FILTER) |=> st.filter_cfg[7:6] == 2'h0
			&& o_lowpass_setting == $past(i_wb.dat[2:0]);
	endproperty
	a_filter_reserved: assert property (p_filter_reserved)
		else $error("filter register fields stored wrongly");

	property p_gyro_cfg;
		s_bus_write(`MSRC_ADR_GYRO) |=> st.gyro_cfg[2:0] == 3'h0
			&& o_gyro_selftest == $past(i_wb.dat[7:5])
			&& o_gyro_range == $past(i_wb.dat[4:3]);
	endproperty
	a_gyro_cfg: assert property (p_gyro_cfg)
		else $error("gyro config stored wrongly");

	property p_accel_cfg;
		s_bus_write(`MSRC_ADR_ACCEL)
			|=> o_accel_selftest == $past(i_wb.dat[7:5])
			&& o_accel_range == $past(i_wb.dat[4:3]);
	endproperty
	a_accel_cfg: assert property (p_accel_cfg)
		else $error("accel config stored wrongly");

	property p_divider_read;
		s_bus_read(`MSRC_ADR_DIVIDER) |=> o_wb_ack
			&& o_wb_dat == $past(st.divider);
	endproperty
	a_divider_read: assert property (p_divider_read)
		else $error("divider read back differs from register");

	property p_rate_status;
		s_bus_read(`MSRC_ADR_STATUS)
			|=> o_wb_dat[`MSRC_STAT_FAST] == $past(gyro_fast(lpf));
	endproperty
	a_rate_status: assert property (p_rate_status)
		else $error("status does not show the gyro output rate");

	property p_accel_hold;
		$changed(st.accel_hold) |-> st.accel_cnt == '0;
	endproperty
	a_accel_hold: assert property (p_accel_hold)
		else $error("accel hold refreshed off its own rate");

	property p_tick_on_gyro;
		o_sample_tick |-> $past(st.gyro_tick);
	endproperty
	a_tick_on_gyro: assert property (p_tick_on_gyro)
		else $error("sample tick without a gyro tick before it");

	property p_ack_pulse;
		i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("bus ack is not a one-cycle answer");
endmodule : motion_sample_rate_config

// File: design/msrc_params.svh
/*
 * constants of the sample-rate and front-end configuration block:
 * register offsets, field positions, reset values and rates.
 * assumes it is included by bare name, once or more.
 */
`ifndef MSRC_PARAMS_SVH
`define MSRC_PARAMS_SVH

// --------------------------------------------------------------
// clock and rates
// --------------------------------------------------------------
`define MSRC_CLK_HZ         20000000
`define MSRC_GYRO_FAST_HZ   8000
`define MSRC_GYRO_SLOW_HZ   1000
`define MSRC_ACCEL_HZ       1000
`define MSRC_CNT_W          15

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define MSRC_ADR_DIVIDER    8'h19
`define MSRC_ADR_FILTER     8'h1A
`define MSRC_ADR_GYRO       8'h1B
`define MSRC_ADR_ACCEL      8'h1C
`define MSRC_ADR_STATUS     8'h1D

// --------------------------------------------------------------
// fields, masks and reset values
// --------------------------------------------------------------
`define MSRC_REG_RESET      8'h00
`define MSRC_FILTER_MASK    8'h3F
`define MSRC_RANGE_MASK     8'hF8
`define MSRC_SLOT_HI        5
`define MSRC_SLOT_LO        3
`define MSRC_LPF_HI         2
`define MSRC_LPF_LO         0
`define MSRC_ST_HI          7
`define MSRC_ST_LO          5
`define MSRC_RNG_HI         4
`define MSRC_RNG_LO         3
`define MSRC_STAT_FAST      0
`define MSRC_STAT_SYNC      1
`define MSRC_LPF_OFF_A      3'h0
`define MSRC_LPF_OFF_B      3'h7
`define MSRC_SLOT_OFF       3'h0
`define MSRC_SLOT_TEMP      3'h1
`define MSRC_SLOT_GYRO      3'h2
`define MSRC_SLOT_ACCEL     3'h5
`define MSRC_RD_NONE        8'h00

`endif

// File: design/msrc_pkg.sv
/*
 * types of the sample-rate and front-end configuration block.
 * assumes msrc_params.svh is on the include path.
 */
package msrc_pkg;
	`include "msrc_params.svh"

	// one set of sensor words, axes x, y, z at index 0, 1, 2
	typedef struct packed {
		logic [15:0]       temp;
		logic [2:0][15:0]  gyro;
		logic [2:0][15:0]  accel;
	} sample_s;

	// classic wishbone request, 8-bit data
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic        sel;
		logic [7:0]  adr;
		logic [7:0]  dat;
	} wb_req_s;

	// whole state of the block
	typedef struct packed {
		logic                   fs_s1;
		logic                   fs_s2;
		logic                   fs_latch;
		logic                   fs_sampled;
		logic [`MSRC_CNT_W-1:0] gyro_cnt;
		logic [`MSRC_CNT_W-1:0] accel_cnt;
		logic                   gyro_tick;
		logic                   sample_tick;
		logic [7:0]             div_cnt;
		logic [7:0]             divider;
		logic [7:0]             filter_cfg;
		logic [7:0]             gyro_cfg;
		logic [7:0]             accel_cfg;
		logic [2:0][15:0]       accel_hold;
		sample_s                sample;
		logic                   ack;
		logic [7:0]             rdata;
	} state_s;
endpackage : msrc_pkg

// File: dv/front_end_model.sv
/*
 * sensing front end model: gyro, accel and temp words on the block clock.
 * assumes the block drives self-test actuators as one bit per axis, x high.
 */
`timescale 1ns/10ps
module front_end_model (
	// clock and pattern mode
	input  wire logic       i_clk_sys,
	input  wire logic       i_vary,
	// actuator drive from the block
	input  wire logic [2:0] i_gyro_selftest,
	input  wire logic [2:0] i_accel_selftest,
	// sensor words
	output msrc_pkg::sample_s o_front
);
	import msrc_pkg::*;

	logic [15:0] cnt = 16'h0000;
	logic [15:0] v;

	always_ff @(posedge i_clk_sys) begin
		cnt <= cnt + 16'h0001;
	end
	// a varying pattern makes every fresh sample differ from the last
	assign v = i_vary ? cnt : 16'h0000;
	always_comb begin
		o_front.temp = 16'h1000 + v;
		for (int i = 0; i < 3; i++) begin
			o_front.gyro[i] = 16'h1020 + 16'h0020 * 16'(i) + v +
				(i_gyro_selftest[2 - i] ? 16'h0100 : 16'h0000);
			o_front.accel[i] = 16'h1080 + 16'h0020 * 16'(i) + v +
				(i_accel_selftest[2 - i] ? 16'h0100 : 16'h0000);
		end
	end
endmodule : front_end_model

// File: dv/motion_sample_rate_config_tb.sv
/*
 * self-checking bench: registers over wishbone, rates, frame sync, self-test.
 * assumes the design is built with short rate periods 5, 40 and 40.
 */
`timescale 1ns/10ps
module motion_sample_rate_config_tb;
	import msrc_pkg::*;
	localparam int FAST = 5;
	localparam int SLOW = 40;
	logic       i_clk_sys, i_sys_rst, i_frame_sync, vary, o_wb_ack;
	logic       o_sample_tick;
	wb_req_s    wb;
	logic [7:0] o_wb_dat, q, d, v;
	logic [2:0] o_gyro_selftest, o_accel_selftest, o_lowpass_setting;
	logic [1:0] o_gyro_range, o_accel_range;
	sample_s    front, o_sample, prev;
	int         n_fail, comparisons, p, gc, ac;

	motion_sample_rate_config #(.GYRO_FAST_CYCLES(FAST),
		.GYRO_SLOW_CYCLES(SLOW), .ACCEL_CYCLES(40)) DUT (.i_clk_sys,
		.i_sys_rst, .i_wb(wb), .o_wb_ack, .o_wb_dat, .i_frame_sync,
		.i_front(front), .o_gyro_selftest, .o_accel_selftest, .o_gyro_range,
		.o_accel_range, .o_lowpass_setting, .o_sample_tick, .o_sample);
	front_end_model FE (.i_clk_sys, .i_vary(vary), .i_gyro_selftest(
		o_gyro_selftest), .i_accel_selftest(o_accel_selftest),
		.o_front(front));

	task automatic tally_and_finish();
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic fault(input string m);
		n_fail++;
		$display("Error %0t %s", $time, m);
	endtask : fault
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) fault(m);
	endtask : chk
	// one classic cycle; returns one edge after release
	task automatic bus(input logic we, input logic [7:0] a, dw);
		int n;
		wb <= '{1'b1, 1'b1, we, 1'b1, a, dw};
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			fault("bus timeout");
			tally_and_finish();
		end
		q = o_wb_dat;
		wb.cyc <= 1'b0;
		wb.stb <= 1'b0;
		@(posedge i_clk_sys);
	endtask : bus
	task automatic wtick(output int c);
		c = 0;
		do begin
			@(posedge i_clk_sys);
			c++;
		end while (o_sample_tick !== 1'b1 && c < 3000);
		if (c >= 3000) begin
			fault("tick timeout");
			tally_and_finish();
		end
	endtask : wtick
	function automatic sample_s exp_s(input logic [2:0] sl, input logic b,
		input logic [2:0] gs, input logic [2:0] as);
		sample_s s;
		s.temp = 16'h1000;
		for (int i = 0; i < 3; i++) begin
			s.gyro[i] = 16'h1020 + 16'h0020 * 16'(i) +
				(gs[2 - i] ? 16'h0100 : 16'h0000);
			s.accel[i] = 16'h1080 + 16'h0020 * 16'(i) +
				(as[2 - i] ? 16'h0100 : 16'h0000);
		end
		if (sl == 3'h1) s.temp[0] = b;
		else if (sl >= 3'h5) s.accel[sl - 3'h5][0] = b;
		else if (sl != 3'h0) s.gyro[sl - 3'h2][0] = b;
		return s;
	endfunction : exp_s

	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		n_fail = 0;
		comparisons = 0;
		i_sys_rst = 1'b1;
		i_frame_sync = 1'b0;
		vary = 1'b0;
		wb = '0;
		p = $urandom(32'h4529d928);
		repeat (4) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		for (int a = 8'h19; a <= 8'h40; a += (a == 8'h1D) ? 35 : 1) begin
			bus(1'b0, 8'(a), 8'h00);
			// status shows the 8 kHz gyro rate while lowpass is 0 or 7
			chk(q === ((a == 8'h1D) ? 8'h01 : 8'h00), "reset value");
			bus(1'b1, 8'(a), 8'hFF);
			bus(1'b0, 8'(a), 8'h00);
			v = (a == 8'h19) ? 8'hFF : (a == 8'h1A) ? 8'h3F :
				(a == 8'h1D) ? 8'h01 : 8'hF8;
			chk(q === ((a > 8'h1D) ? 8'h00 : v), "field mask");
		end
		repeat (8) begin
			v = 8'($urandom);
			bus(1'b1, 8'h1B, v);
			chk({o_gyro_selftest, o_gyro_range} === v[7:3], "gyro");
			bus(1'b1, 8'h1C, v);
			chk({o_accel_selftest, o_accel_range} === v[7:3], "acc");
			bus(1'b1, 8'h1A, v);
			chk(o_lowpass_setting === v[2:0], "lowpass");
		end
		bus(1'b1, 8'h1B, 8'h00);
		bus(1'b1, 8'h1C, 8'h10);
		for (int l = 0; l < 8; l++) begin
			d = (l == 0) ? 8'hFF : 8'($urandom_range(3));
			bus(1'b1, 8'h1A, 8'(l));
			bus(1'b1, 8'h19, d);
			wtick(p);
			wtick(p);
			wtick(p);
			chk(p == ((l == 0 || l == 7) ? FAST : SLOW) * (int'(d) + 1),
				"rate");
		end
		bus(1'b1, 8'h19, 8'h00);
		i_frame_sync <= 1'b1;
		for (int sl = 0; sl < 8; sl++) begin
			bus(1'b1, 8'h1A, {2'b00, 3'(sl), 3'h1});
			wtick(p);
			wtick(p);
			chk(o_sample === exp_s(3'(sl), 1'b1, 3'h0, 3'h0),
				"sync slot");
		end
		bus(1'b1, 8'h1A, 8'h09);
		i_frame_sync <= 1'b0;
		repeat (3) wtick(p);
		repeat (3) @(posedge i_clk_sys);
		i_frame_sync <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_frame_sync <= 1'b0;
		wtick(p);
		chk(o_sample.temp[0] === 1'b1, "strobe lost");
		wtick(p);
		chk(o_sample.temp[0] === 1'b0, "latch kept");
		bus(1'b1, 8'h1B, 8'hA0);
		bus(1'b1, 8'h1C, 8'h50);
		wtick(p);
		wtick(p);
		chk(o_sample === exp_s(3'h1, 1'b0, 3'h5, 3'h2), "self-test");
		vary <= 1'b1;
		bus(1'b1, 8'h1A, 8'h00);
		wtick(p);
		wtick(p);
		prev = o_sample;
		gc = 0;
		ac = 0;
		repeat (16) begin
			wtick(p);
			gc += int'(o_sample.gyro[0] !== prev.gyro[0]);
			ac += int'(o_sample.accel[0] !== prev.accel[0]);
			prev = o_sample;
		end
		chk(gc == 16 && ac >= 1 && ac <= 3, "pacing");
		tally_and_finish();
	end
endmodule : motion_sample_rate_config_tb
